/* File: startup_defs.svh */
// Constants for the start-up reset and clock configuration block
`ifndef STARTUP_DEFS_SVH
`define STARTUP_DEFS_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADDR_POWER_MGMT 12'h000
`define ADDR_RUNRST 12'h004
`define ADDR_STATUS 12'h008

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define RUNRST_EN_BIT 0
`define PM_MULT_LSB 0
`define PM_DIV_LSB 8
`define PM_APPLY_BIT 16
`define POWER_MGMT_RESET 32'h0000_0000

// ---------------------------------------------------------------
// Ratio codes from the strap pins
// ---------------------------------------------------------------
`define RATIO_CODE_8 2'h0
`define RATIO_CODE_32 2'h1
`define RATIO_CODE_16 2'h2
`define RATIO_8 8'h08
`define RATIO_32 8'h20
`define RATIO_16 8'h10

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LOCK_CYCLES 4096

`endif

/* File: startup_pkg.sv */
// Types shared by the start-up sequencer
package startup_pkg;

	// Sequencer phases
	typedef enum logic [1:0] {
		ST_LOCK_WAIT,
		ST_RUN
	} seq_state_e;

	// Clock setting as seen by the core clock generator
	typedef struct packed {
		logic [7:0] mult;
		logic [7:0] div;
		logic valid;
	} clk_setting_s;

	// Latched strap values
	typedef struct packed {
		logic [1:0] ratio_code;
		logic [2:0] boot_mode;
	} strap_s;

endpackage

/* File: lock_counter.sv */
// Lock-wait counter that holds the core until the PLL settles
`timescale 1ns/1ps
`include "startup_defs.svh"

module lock_counter #(
	parameter int LOCK_COUNT = `LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic done
);
	localparam int CW = $clog2(LOCK_COUNT + 1);
	localparam logic [CW-1:0] TERM = CW'(LOCK_COUNT);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;

	// Count up to the lock figure, then stick
	always_comb begin
		next_count = count;
		if (count != TERM) begin
			next_count = count + CW'(1);
		end
	end

	// Restarts on every reset assertion
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign done = (count == TERM);

endmodule // lock_counter

/* File: startup_seq.sv */
// Start-up reset and clock configuration sequencer with AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "startup_defs.svh"

// Contract
// - strap code picks 8, 32 or 16 ratio
// - software clock fields change frequency after reset
// - wait 4096 reference clocks after reset release
// - then start fetching at reset vector
// - dual pin is reset output by default
// - control bit 0 turns pin into input
module startup_seq
	import startup_pkg::*;
#(
	parameter int LOCK_COUNT = `LOCK_CYCLES,
	parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] ratio_strap,
	input wire logic [2:0] boot_strap,
	input wire logic reset_output_pin_i,
	output logic reset_output_pin_o,
	output logic reset_output_pin_oe,
	output logic core_rst_n,
	output logic fetch_start,
	output logic [31:0] fetch_addr,
	output logic [2:0] boot_mode,
	output clk_setting_s clk_setting,
	output logic running_reset_input,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	// ---------------------------------------------------------------
	// Lock wait
	// ---------------------------------------------------------------
	logic lock_done;

	// Reset restarts the count, so any reassertion re-arms the wait
	lock_counter #(.LOCK_COUNT(LOCK_COUNT)) u_lock (
		.clk(clk),
		.rst_n(rst_n),
		.done(lock_done)
	);

	seq_state_e state;
	seq_state_e next_state;
	strap_s straps;
	strap_s next_straps;
	logic [31:0] power_mgmt_control_reg;
	logic [31:0] next_power_mgmt;
	logic [31:0] running_reset_control_reg;
	logic [31:0] next_runrst;
	clk_setting_s next_clk_setting;
	logic wr_pend;
	logic next_wr_pend;
	logic [11:0] wr_addr;
	logic [11:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_fetch_start;

	// ---------------------------------------------------------------
	// Strap capture and state
	// ---------------------------------------------------------------
	function automatic logic [7:0] ratio_of(input logic [1:0] code);
		unique case (code)
			`RATIO_CODE_8: ratio_of = `RATIO_8;
			`RATIO_CODE_32: ratio_of = `RATIO_32;
			`RATIO_CODE_16: ratio_of = `RATIO_16;
			default: ratio_of = `RATIO_8; // Reserved code falls back
		endcase
	endfunction

	// Straps cleared in reset, tracked during the lock wait, frozen once running
	always_comb begin
		next_straps = straps;
		next_state = state;
		next_fetch_start = 1'b0;
		unique case (state)
			ST_LOCK_WAIT: begin
				next_straps.ratio_code = ratio_strap;
				next_straps.boot_mode = boot_strap;
				if (lock_done) begin
					next_state = ST_RUN;
					next_fetch_start = 1'b1;
				end
			end
			ST_RUN: begin
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Bus slave and registers
	// ---------------------------------------------------------------
	wire addr_ok = hsel && hready && htrans[1];

	// Writes land in data phase; clock fields only in ST_RUN with the apply bit set
	always_comb begin
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = addr_ok ? haddr : wr_addr;
		next_power_mgmt = power_mgmt_control_reg;
		next_runrst = running_reset_control_reg;
		next_clk_setting = clk_setting;
		next_hrdata = hrdata;
		if (state == ST_LOCK_WAIT) begin
			next_clk_setting.mult = ratio_of(straps.ratio_code);
			next_clk_setting.div = 8'h01;
			next_clk_setting.valid = 1'b0;
		end else begin
			next_clk_setting.valid = 1'b1;
		end
		if (wr_pend) begin
			unique case (wr_addr)
				`ADDR_POWER_MGMT: begin
					next_power_mgmt = hwdata;
					if (state == ST_RUN && hwdata[`PM_APPLY_BIT]) begin
						next_clk_setting.mult = hwdata[`PM_MULT_LSB +: 8];
						next_clk_setting.div = hwdata[`PM_DIV_LSB +: 8];
					end
				end
				`ADDR_RUNRST: next_runrst = {31'h0, hwdata[`RUNRST_EN_BIT]};
				default: ;
			endcase
		end
		if (addr_ok && !hwrite) begin
			unique case (haddr)
				`ADDR_POWER_MGMT: next_hrdata = power_mgmt_control_reg;
				`ADDR_RUNRST: next_hrdata = running_reset_control_reg;
				`ADDR_STATUS: next_hrdata = {24'h0, straps.ratio_code,
					straps.boot_mode, 2'h0, state == ST_RUN};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Register everything; pin role resets to output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_LOCK_WAIT;
			straps <= '0;
			power_mgmt_control_reg <= `POWER_MGMT_RESET;
			running_reset_control_reg <= 32'h0000_0000;
			clk_setting <= '0;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			fetch_start <= 1'b0;
		end else begin
			state <= next_state;
			straps <= next_straps;
			power_mgmt_control_reg <= next_power_mgmt;
			running_reset_control_reg <= next_runrst;
			clk_setting <= next_clk_setting;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			fetch_start <= next_fetch_start;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign core_rst_n = (state == ST_RUN);
	assign fetch_addr = RESET_VECTOR;
	assign boot_mode = straps.boot_mode;
	// Pin drives core reset unless software hands it to the input role
	assign reset_output_pin_oe = !running_reset_control_reg[`RUNRST_EN_BIT];
	assign reset_output_pin_o = core_rst_n;
	assign running_reset_input = running_reset_control_reg[`RUNRST_EN_BIT]
		? reset_output_pin_i : 1'b1;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	int unsigned run_cnt;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_cnt <= 0;
		end else if (run_cnt < LOCK_COUNT + 2) begin
			run_cnt <= run_cnt + 1;
		end
	end

	core_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(run_cnt < LOCK_COUNT) |-> !core_rst_n)
		else $error("core released before lock wait");
	core_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		(run_cnt >= LOCK_COUNT + 1) |-> core_rst_n)
		else $error("core not released after lock wait");
	fetch_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(core_rst_n) |-> fetch_start ##1 !fetch_start)
		else $error("fetch start not one pulse at release");
	pin_default_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> reset_output_pin_oe)
		else $error("reset pin not output after reset");
	pin_role_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_pend && wr_addr == `ADDR_RUNRST) |=>
		reset_output_pin_oe != $past(hwdata[`RUNRST_EN_BIT]))
		else $error("pin role differs from written control bit");
	ratio_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_LOCK_WAIT && straps.ratio_code == 2'h1) |=>
		clk_setting.mult == 8'h20)
		else $error("ratio code 01 not 32");
	clk_change_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_pend && wr_addr == `ADDR_POWER_MGMT && state == ST_RUN
		&& hwdata[16]) |=> clk_setting.mult == $past(hwdata[7:0]))
		else $error("clock field write not applied");
	clk_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_LOCK_WAIT) |=> !clk_setting.valid)
		else $error("clock setting valid during lock wait");

endmodule // startup_seq

/* File: board_model.sv */
// Board model: reset source, strap resistors and the dual reset pin pad
`timescale 1ns/1ps

module board_model (
	input wire logic hold_reset,
	input wire logic [1:0] ratio_set,
	input wire logic [2:0] boot_set,
	input wire logic pull_low,
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic rst_n,
	output logic [1:0] ratio_strap,
	output logic [2:0] boot_strap,
	output logic pin_i
);
	// -------------------------------------------------------------
	// Reset and straps
	// -------------------------------------------------------------
	// Reset stays low for as long as supply ramp is requested
	assign rst_n = ~hold_reset;
	// Straps are plain resistors; the bench moves them a cycle before it asserts reset
	assign ratio_strap = ratio_set;
	assign boot_strap = boot_set;
	// -------------------------------------------------------------
	// Pad of the dual reset pin
	// -------------------------------------------------------------
	// Pull-up wins once the device lets go, unless the board pulls low
	assign pin_i = pin_oe ? pin_o : ~pull_low;
endmodule // board_model

/* File: startup_seq_test.sv */
// Testbench for the start-up sequencer and its register port
`timescale 1ns/1ps

module startup_seq_test;
	import startup_pkg::*;
	localparam int LOCK = 16;
	logic clk = 1'b0;
	logic hold_reset = 1'b1;
	logic pull_low = 1'b0;
	logic [1:0] ratio_set = 2'h0;
	logic [2:0] boot_set = 3'h0;
	logic rst_n, pin_i, pin_o, pin_oe, core_rst_n, fetch_start;
	logic [1:0] ratio_strap;
	logic [2:0] boot_strap, boot_mode;
	logic [31:0] fetch_addr, hrdata, q;
	clk_setting_s clk_setting;
	logic running_reset_input, hreadyout, hresp;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	int failures = 0;
	int check_count = 0;
	logic [7:0] ratio_tab [4] = '{8'h08, 8'h20, 8'h10, 8'h08};

	// Free-running reference clock, never halted
	initial begin
		forever #50 clk = ~clk;
	end

	board_model i_board_model (.hold_reset(hold_reset),
		.ratio_set(ratio_set), .boot_set(boot_set), .pull_low(pull_low),
		.pin_o(pin_o), .pin_oe(pin_oe), .rst_n(rst_n),
		.ratio_strap(ratio_strap), .boot_strap(boot_strap), .pin_i(pin_i));

	startup_seq #(.LOCK_COUNT(LOCK)) i_startup_seq (.clk(clk), .rst_n(rst_n),
		.ratio_strap(ratio_strap), .boot_strap(boot_strap),
		.reset_output_pin_i(pin_i), .reset_output_pin_o(pin_o),
		.reset_output_pin_oe(pin_oe), .core_rst_n(core_rst_n),
		.fetch_start(fetch_start), .fetch_addr(fetch_addr),
		.boot_mode(boot_mode), .clk_setting(clk_setting),
		.running_reset_input(running_reset_input), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	// Verdict and stop; also the landing place of every timeout
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait for hready at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			failures++;
			end_of_test();
		end
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Reset with new straps, optional early re-reset, count lock wait
	task automatic do_reset(input logic [1:0] r, input logic [2:0] b,
		input int abort);
		int n;
		// Straps settle a cycle before reset goes low
		@(posedge clk);
		ratio_set <= r;
		boot_set <= b;
		@(posedge clk);
		hold_reset <= 1'b1;
		repeat (8) @(posedge clk);
		hold_reset <= 1'b0;
		if (abort > 0) begin
			repeat (abort) @(posedge clk);
			hold_reset <= 1'b1;
			@(posedge clk);
			hold_reset <= 1'b0;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (core_rst_n !== 1'b1 && n < 100);
		chk(32'(n), 32'(LOCK + 1));
		if (core_rst_n !== 1'b1) begin
			end_of_test();
		end
		chk({31'h0, fetch_start}, 32'h1);
		chk(fetch_addr, 32'h0000_0000);
		chk({31'h0, pin_i}, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, fetch_start}, 32'h0);
	endtask

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		// Every ratio code, one run with a re-reset in mid-wait
		for (int c = 0; c < 4; c++) begin
			do_reset(2'(c), 3'(c + 3), (c == 2) ? 5 : 0);
			chk({24'h0, clk_setting.mult}, {24'h0, ratio_tab[c]});
			chk({29'h0, boot_mode}, 32'(c + 3));
			chk({31'h0, pin_oe}, 32'h1);
			bus(1'b0, 12'h008, 32'h0);
			chk(q, {24'h0, 2'(c), 3'(c + 3), 2'h0, 1'b1});
			$display("test reset with ratio code %0d done", c);
		end
		// Device drives the pin, so a board pull-down is not seen
		pull_low <= 1'b1;
		@(posedge clk);
		#1;
		chk({31'h0, running_reset_input}, 32'h1);
		bus(1'b1, 12'h004, 32'h0000_0001);
		@(posedge clk);
		#1;
		chk({31'h0, pin_oe}, 32'h0);
		chk({31'h0, running_reset_input}, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		chk(q, 32'h0000_0001);
		$display("test pin role done");
		// Program a new clock setting while running
		bus(1'b1, 12'h000, 32'h0001_0305);
		// Setting lands at the data-phase edge; look once it has settled
		#1;
		chk({15'h0, clk_setting}, {15'h0, 8'h05, 8'h03, 1'b1});
		bus(1'b0, 12'h00C, 32'h0);
		chk(q, 32'h0000_0000);
		$display("test clock program done");
		// Reset with the pin in input role: output role must come back
		do_reset(2'h1, 3'h2, 0);
		chk({31'h0, pin_oe}, 32'h1);
		chk({24'h0, clk_setting.mult}, 32'h0000_0020);
		bus(1'b0, 12'h004, 32'h0);
		chk(q, 32'h0000_0000);
		$display("test reset after pin role done");
		end_of_test();
	end
endmodule // startup_seq_test
